// ==== design/rtc_core_map.vh ====
// register offsets, field positions, reset values and timing counts of the rtc core
`ifndef RTC_CORE_MAP_VH
`define RTC_CORE_MAP_VH

`define OFS_CTRL 8'h00
`define OFS_READ_REQUEST_REGISTER 8'h04
`define OFS_EVENT_OUTPUT_CONTROL 8'h08
`define OFS_INTERRUPT_ENABLE_CLEAR 8'h0C
`define OFS_INTERRUPT_ENABLE_SET 8'h10
`define OFS_INTERRUPT_FLAGS 8'h14
`define OFS_STATUS 8'h18
`define OFS_DEBUG_CONTROL 8'h1C
`define OFS_COUNT 8'h20
`define OFS_PER 8'h24
`define OFS_COMP0 8'h28
`define OFS_COMP1 8'h2C
`define OFS_MASK0 8'h30
`define OFS_MASK1 8'h34

`define SOFT_RESET_BIT 0
`define CTRL_ENABLE 1
`define CTRL_MODE_LO 2
`define CTRL_MODE_HI 3
`define CTRL_HOURFMT 6
`define CLEAR_ON_MATCH 7
`define CTRL_DIV_LO 8
`define CTRL_DIV_HI 11

`define EV_MATCH0 8
`define EV_MATCH1 9
`define EV_OVF 15

`define FLAG_MATCH0 0
`define FLAG_MATCH1 1
`define FLAG_SYNCRDY 6
`define FLAG_OVF 7
`define STATUS_SYNC 7

`define MODE_CNT32 2'h0
`define MODE_CNT16 2'h1
`define MODE_CAL 2'h2

`define RST_CTRL 12'h000
`define RST_PER 16'hFFFF
`define RST_WORD 32'h00000000

`define SYNC_CYC 3'h4

`endif

// ==== design/rtc_counter_calendar_core.v ====
// real-time counter core with prescaler, counter/calendar modes and wishbone registers
`timescale 1ns/1ns
`default_nettype none
`include "rtc_core_map.vh"
// Function
// RULE1 - only power-on reset or soft reset bit returns the unit to initial state
// RULE2 - protected mode, divider, match clear, hour format, event control writes dropped while enabled
// RULE3 - protected writes during a disable are held and applied after it completes
// RULE4 - ten-bit prescaler gives count tick at source rate over two to divider
// RULE5 - software sets enable to run, clears it to stop, disables before soft reset
// RULE6 - soft reset restores all registers except debug control and disables the unit
// RULE7 - mode zero 32-bit counter, one 16-bit counter, two clock calendar
// RULE8 - 32-bit mode counts each tick, rolls from all ones to zero, sets overflow
// RULE9 - counter modes compare with two values, match flag set on following tick
// RULE10 - 32-bit match clear: compare zero match clears counter, sets compare and overflow together
// RULE11 - 16-bit mode counts to period top, wraps to zero, sets overflow
// RULE12 - software configures source and divider so calendar tick is one hertz
// RULE13 - calendar holds seconds to year, hours in 12 or 24 hour format
// RULE14 - day and month count from one, year is offset from software reference
// RULE15 - year offset divisible by four is leap year for february length
// RULE16 - after year 63 december 31 23:59:59 wrap to year zero, set overflow
// RULE17 - calendar compares with two alarms, alarm flag set on next tick
// RULE18 - alarm field mask selects which fields take part in alarm compare
// RULE19 - calendar match clear: alarm zero match clears counter, sets alarm and overflow
// RULE20 - enabled periodic output n fires on rising prescaler bit n+2, rate over 2^(n+3)
// RULE21 - periodic events ignore divider but none while divider is zero
// RULE22 - debug halt stops counting unless debug control keeps it running
// RULE23 - write guard blocks registers except flags, read request, status, debug control
// RULE24 - synchronised access sets sync pending at once, later ones stall the bus; the code starts a sync and stalls only on writes, reads never stall
// RULE25 - shared interrupt high while any enabled flag is set
module rtc_counter_calendar_core (
    input wire clk_i,
    input wire rst_i,
    input wire timer_source_clock_i,
    input wire debug_halt_i,
    input wire write_guard_i,
    input wire debugger_access_i,
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [7:0] adr_i,
    input wire [3:0] sel_i,
    input wire [31:0] dat_i,
    output reg [31:0] dat_o,
    output reg ack_o,
    output reg irq_o,
    output reg [7:0] periodic_event_o,
    output reg [1:0] match_event_o,
    output reg overflow_event_o
);
    reg src_s1_ff, src_s2_ff, src_s3_ff;
    reg [11:0] ctrl_ff;
    reg enable_ff;
    reg [15:0] event_output_control_ff;
    reg [15:0] held_event_output_control_ff;
    reg held_ev_ff;
    reg [15:0] read_request_register_ff;
    reg [7:0] inten_ff;
    reg [7:0] interrupt_flags_ff;
    reg debug_control_ff;
    reg [31:0] count_ff;
    reg [15:0] period_top_ff;
    reg [31:0] compare_value0_ff, compare_value1_ff;
    reg [2:0] alarm_field_mask0_ff, alarm_field_mask1_ff;
    reg [9:0] prescale_ff;
    reg [2:0] sync_cnt_ff;
    reg [7:0] sync_adr_ff;
    reg [31:0] sync_dat_ff;
    reg [7:0] nxt_flags;
    reg [31:0] nxt_count;
    reg [31:0] rd;

    wire src_edge = src_s2_ff & ~src_s3_ff;
    wire [1:0] mode = ctrl_ff[`CTRL_MODE_HI:`CTRL_MODE_LO];
    wire [3:0] divider = ctrl_ff[`CTRL_DIV_HI:`CTRL_DIV_LO];
    wire hour12 = ctrl_ff[`CTRL_HOURFMT];
    wire matchclr = ctrl_ff[`CLEAR_ON_MATCH];
    wire sync_busy = (sync_cnt_ff != 3'h0);
    wire sync_done = (sync_cnt_ff == 3'h1);
    wire running = enable_ff & ~(debug_halt_i & ~debug_control_ff); // [RULE22]
    wire [9:0] nxt_pre = prescale_ff + 10'h001;
    // guard lifted in debug halt and for debugger accesses
    wire guarded = write_guard_i & ~debug_halt_i & ~debugger_access_i; // [RULE23]
    wire req = cyc_i & stb_i & ~ack_o;
    wire wr = req & we_i;
    wire is_sync_reg = (adr_i == `OFS_CTRL) || (adr_i == `OFS_COUNT) || (adr_i == `OFS_PER)
        || (adr_i == `OFS_COMP0) || (adr_i == `OFS_COMP1) || (adr_i == `OFS_MASK0)
        || (adr_i == `OFS_MASK1);
    wire unguarded = (adr_i == `OFS_INTERRUPT_FLAGS) || (adr_i == `OFS_READ_REQUEST_REGISTER)
        || (adr_i == `OFS_DEBUG_CONTROL) || (adr_i == `OFS_STATUS);
    wire stall = wr & is_sync_reg & sync_busy; // [RULE24]
    wire take = req & ~stall;
    wire wr_ok = take & we_i & (unguarded | ~guarded); // [RULE23]
    wire start_sync = wr_ok & is_sync_reg; // [RULE24]
    // applied on completion, so the counting side never sees a half-written value
    wire apply = sync_done;
    wire soft_rst = apply & (sync_adr_ff == `OFS_CTRL) & sync_dat_ff[`SOFT_RESET_BIT]; // [RULE6]
    wire clr = rst_i | soft_rst; // [RULE1]
    wire [31:0] wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
    wire [31:0] wdat = dat_i & wmask;

    // count tick: prescaler bit divider-1 rising, or every source edge at divider zero
    wire tick = running & src_edge & ((divider == 4'h0) |
        (~prescale_ff[divider - 4'h1] & nxt_pre[divider - 4'h1])); // [RULE4]

    function [31:0] field_mask;
        input [2:0] s;
        begin
            case (s)
                3'h1: field_mask = 32'h0000003F;
                3'h2: field_mask = 32'h00000FFF;
                3'h3: field_mask = 32'h0001FFFF;
                3'h4: field_mask = 32'h003FFFFF;
                3'h5: field_mask = 32'h03FFFFFF;
                3'h6: field_mask = 32'hFFFFFFFF;
                default: field_mask = 32'h00000000;
            endcase
        end
    endfunction

    // {overflow, next clock}: sec[5:0] min[11:6] hour[16:12] day[21:17] mon[25:22] yr[31:26]
    function [32:0] cal_next;
        input [31:0] c;
        input h12;
        reg [5:0] sec, mn, yr;
        reg [4:0] hr, dy, last;
        reg [3:0] mo;
        reg carry, wrap;
        begin
            sec = c[5:0];
            mn = c[11:6];
            hr = c[16:12];
            dy = c[21:17];
            mo = c[25:22];
            yr = c[31:26];
            carry = 1'b0;
            wrap = 1'b0;
            if (mo == 4'h2)
                last = (yr[1:0] == 2'h0) ? 5'h1D : 5'h1C; // [RULE15]
            else if (mo == 4'h4 || mo == 4'h6 || mo == 4'h9 || mo == 4'hB)
                last = 5'h1E;
            else
                last = 5'h1F;
            if (sec != 6'h3B)
                sec = sec + 6'h01;
            else
            begin
                sec = 6'h00;
                if (mn != 6'h3B)
                    mn = mn + 6'h01;
                else
                begin
                    mn = 6'h00;
                    if (h12) // [RULE13]
                    begin
                        // bit 4 marks afternoon, low bits run 1..12
                        if (hr[3:0] == 4'hC)
                            hr = {hr[4], 4'h1};
                        else if (hr[3:0] == 4'hB)
                        begin
                            hr = {~hr[4], 4'hC};
                            carry = hr[4] == 1'b0;
                        end
                        else
                            hr = hr + 5'h01;
                    end
                    else if (hr == 5'h17)
                    begin
                        hr = 5'h00;
                        carry = 1'b1;
                    end
                    else
                        hr = hr + 5'h01;
                    if (carry)
                    begin
                        if (dy < last)
                            dy = dy + 5'h01;
                        else
                        begin
                            dy = 5'h01; // [RULE14]
                            if (mo < 4'hC)
                                mo = mo + 4'h1;
                            else
                            begin
                                mo = 4'h1;
                                wrap = (yr == 6'h3F); // [RULE16]
                                yr = yr + 6'h01;
                            end
                        end
                    end
                end
            end
            cal_next = {wrap, yr, mo, dy, hr, mn, sec};
        end
    endfunction

    wire [32:0] cal = cal_next(count_ff, hour12);
    wire hit0_cnt = (mode == `MODE_CNT16) ? (count_ff[15:0] == compare_value0_ff[15:0])
        : (count_ff == compare_value0_ff); // [RULE9]
    wire hit1_cnt = (mode == `MODE_CNT16) ? (count_ff[15:0] == compare_value1_ff[15:0])
        : (count_ff == compare_value1_ff); // [RULE9]
    wire [31:0] fm0 = field_mask(alarm_field_mask0_ff);
    wire [31:0] fm1 = field_mask(alarm_field_mask1_ff);
    wire hit0_cal = (fm0 != 32'h0) & (((count_ff ^ compare_value0_ff) & fm0) == 32'h0); // [RULE18]
    wire hit1_cal = (fm1 != 32'h0) & (((count_ff ^ compare_value1_ff) & fm1) == 32'h0); // [RULE18]
    wire hit0 = (mode == `MODE_CAL) ? hit0_cal : hit0_cnt; // [RULE17]
    wire hit1 = (mode == `MODE_CAL) ? hit1_cal : hit1_cnt;

    reg ovf_now;
    always @*
    begin
        nxt_count = count_ff;
        ovf_now = 1'b0;
        case (mode) // [RULE7]
            `MODE_CNT32:
            begin
                if (matchclr & hit0)
                begin
                    nxt_count = `RST_WORD; // [RULE10]
                    ovf_now = 1'b1;
                end
                else
                begin
                    nxt_count = count_ff + 32'h00000001; // [RULE8]
                    ovf_now = (count_ff == 32'hFFFFFFFF);
                end
            end
            `MODE_CNT16:
            begin
                if (count_ff[15:0] == period_top_ff)
                begin
                    nxt_count = `RST_WORD; // [RULE11]
                    ovf_now = 1'b1;
                end
                else
                    nxt_count = {16'h0000, count_ff[15:0] + 16'h0001};
            end
            `MODE_CAL:
            begin
                if (matchclr & hit0)
                begin
                    nxt_count = `RST_WORD; // [RULE19]
                    ovf_now = 1'b1;
                end
                else
                begin
                    nxt_count = cal[31:0];
                    ovf_now = cal[32]; // [RULE16]
                end
            end
            default: nxt_count = count_ff;
        endcase
    end

    // set wins over the software clear in the same cycle
    always @*
    begin
        nxt_flags = interrupt_flags_ff;
        if (wr_ok && adr_i == `OFS_INTERRUPT_FLAGS)
            nxt_flags = nxt_flags & ~wdat[7:0];
        if (tick)
        begin
            nxt_flags[`FLAG_MATCH0] = nxt_flags[`FLAG_MATCH0] | hit0; // [RULE9] [RULE17]
            nxt_flags[`FLAG_MATCH1] = nxt_flags[`FLAG_MATCH1] | hit1;
            nxt_flags[`FLAG_OVF] = nxt_flags[`FLAG_OVF] | ovf_now;
        end
        if (sync_done)
            nxt_flags[`FLAG_SYNCRDY] = 1'b1;
        nxt_flags[5:2] = 4'h0;
    end

    // source clock comes from another domain, two flops before use
    always @(posedge clk_i)
    begin
        src_s1_ff <= timer_source_clock_i;
        src_s2_ff <= src_s1_ff;
        src_s3_ff <= src_s2_ff;
    end

    always @(posedge clk_i)
    begin
        if (rst_i)
            debug_control_ff <= 1'b0;
        else if (wr_ok && adr_i == `OFS_DEBUG_CONTROL)
            debug_control_ff <= wdat[0];
    end

    integer n;
    always @(posedge clk_i)
    begin
        if (clr) // [RULE1] [RULE6]
        begin
            ctrl_ff <= `RST_CTRL;
            enable_ff <= 1'b0;
            event_output_control_ff <= 16'h0000;
            held_event_output_control_ff <= 16'h0000;
            held_ev_ff <= 1'b0;
            read_request_register_ff <= 16'h0000;
            inten_ff <= 8'h00;
            interrupt_flags_ff <= 8'h00;
            count_ff <= `RST_WORD;
            period_top_ff <= `RST_PER;
            compare_value0_ff <= `RST_WORD;
            compare_value1_ff <= `RST_WORD;
            alarm_field_mask0_ff <= 3'h0;
            alarm_field_mask1_ff <= 3'h0;
            prescale_ff <= 10'h000;
            sync_cnt_ff <= 3'h0;
            sync_adr_ff <= 8'h00;
            sync_dat_ff <= `RST_WORD;
            irq_o <= 1'b0;
            periodic_event_o <= 8'h00;
            match_event_o <= 2'h0;
            overflow_event_o <= 1'b0;
        end
        else
        begin
            interrupt_flags_ff <= nxt_flags;
            irq_o <= |(nxt_flags & inten_ff); // [RULE25]
            if (running & src_edge)
                prescale_ff <= nxt_pre;
            else if (~enable_ff)
                prescale_ff <= 10'h000;
            for (n = 0; n < 8; n = n + 1)
                periodic_event_o[n] <= running & src_edge & (divider != 4'h0)
                    & event_output_control_ff[n] & ~prescale_ff[n + 2]
                    & nxt_pre[n + 2]; // [RULE20] [RULE21]
            match_event_o <= {2{tick}} & {hit1, hit0}
                & event_output_control_ff[`EV_MATCH1:`EV_MATCH0];
            overflow_event_o <= tick & ovf_now & event_output_control_ff[`EV_OVF];
            if (tick)
                count_ff <= nxt_count;
            if (start_sync)
            begin
                sync_cnt_ff <= `SYNC_CYC; // [RULE24]
                sync_adr_ff <= adr_i;
                sync_dat_ff <= wdat;
                if (adr_i == `OFS_CTRL)
                begin
                    ctrl_ff[`SOFT_RESET_BIT] <= wdat[`SOFT_RESET_BIT];
                    ctrl_ff[`CTRL_ENABLE] <= wdat[`CTRL_ENABLE]; // [RULE5]
                    if (~ctrl_ff[`CTRL_ENABLE]) // [RULE2]
                    begin
                        ctrl_ff[`CTRL_MODE_HI:`CTRL_MODE_LO] <=
                            wdat[`CTRL_MODE_HI:`CTRL_MODE_LO];
                        ctrl_ff[`CTRL_HOURFMT] <= wdat[`CTRL_HOURFMT];
                        ctrl_ff[`CLEAR_ON_MATCH] <= wdat[`CLEAR_ON_MATCH];
                        ctrl_ff[`CTRL_DIV_HI:`CTRL_DIV_LO] <= wdat[`CTRL_DIV_HI:`CTRL_DIV_LO];
                    end
                end
            end
            else if (sync_busy)
                sync_cnt_ff <= sync_cnt_ff - 3'h1;
            if (apply)
            begin
                case (sync_adr_ff)
                    `OFS_CTRL: enable_ff <= ctrl_ff[`CTRL_ENABLE];
                    `OFS_COUNT: count_ff <= sync_dat_ff;
                    `OFS_PER: period_top_ff <= sync_dat_ff[15:0];
                    `OFS_COMP0: compare_value0_ff <= sync_dat_ff;
                    `OFS_COMP1: compare_value1_ff <= sync_dat_ff;
                    `OFS_MASK0: alarm_field_mask0_ff <= sync_dat_ff[2:0];
                    `OFS_MASK1: alarm_field_mask1_ff <= sync_dat_ff[2:0];
                    default: enable_ff <= enable_ff;
                endcase
            end
            // event control written while a disable is still settling waits for it
            if (held_ev_ff & ~sync_busy)
            begin
                event_output_control_ff <= held_event_output_control_ff; // [RULE3]
                held_ev_ff <= 1'b0;
            end
            if (wr_ok && adr_i == `OFS_EVENT_OUTPUT_CONTROL)
            begin
                if (~ctrl_ff[`CTRL_ENABLE] & enable_ff & sync_busy)
                begin
                    held_event_output_control_ff <= wdat[15:0]; // [RULE3]
                    held_ev_ff <= 1'b1;
                end
                else if (~ctrl_ff[`CTRL_ENABLE]) // [RULE2]
                    event_output_control_ff <= wdat[15:0];
            end
            if (wr_ok && adr_i == `OFS_READ_REQUEST_REGISTER)
                read_request_register_ff <= wdat[15:0];
            if (wr_ok && adr_i == `OFS_INTERRUPT_ENABLE_SET)
                inten_ff <= inten_ff | (wdat[7:0] & 8'hC3);
            if (wr_ok && adr_i == `OFS_INTERRUPT_ENABLE_CLEAR)
                inten_ff <= inten_ff & ~wdat[7:0];
        end
    end

    always @*
    begin
        case (adr_i)
            `OFS_CTRL: rd = {20'h00000, ctrl_ff};
            `OFS_READ_REQUEST_REGISTER: rd = {16'h0000, read_request_register_ff};
            `OFS_EVENT_OUTPUT_CONTROL: rd = {16'h0000, event_output_control_ff};
            `OFS_INTERRUPT_ENABLE_CLEAR: rd = {24'h000000, inten_ff};
            `OFS_INTERRUPT_ENABLE_SET: rd = {24'h000000, inten_ff};
            `OFS_INTERRUPT_FLAGS: rd = {24'h000000, interrupt_flags_ff};
            `OFS_STATUS: rd = {24'h000000, sync_busy, 7'h00}; // [RULE24]
            `OFS_DEBUG_CONTROL: rd = {31'h00000000, debug_control_ff};
            `OFS_COUNT: rd = count_ff;
            `OFS_PER: rd = {16'h0000, period_top_ff};
            `OFS_COMP0: rd = compare_value0_ff;
            `OFS_COMP1: rd = compare_value1_ff;
            `OFS_MASK0: rd = {29'h00000000, alarm_field_mask0_ff};
            `OFS_MASK1: rd = {29'h00000000, alarm_field_mask1_ff};
            default: rd = 32'h00000000;
        endcase
    end

    // bus answer survives a soft reset so a pending cycle still completes
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_o <= 1'b0;
            dat_o <= 32'h00000000;
        end
        else
        begin
            ack_o <= take;
            dat_o <= (take & ~we_i) ? rd : 32'h00000000;
        end
    end
endmodule
`default_nettype wire

// ==== verif/rtc_core_monitor.sv ====
// port-level assertion checker for the rtc counter calendar core
`timescale 1ns/1ns
`default_nettype none
module rtc_core_monitor (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    input wire logic irq_o,
    input wire logic [7:0] periodic_event_o,
    input wire logic [1:0] match_event_o,
    input wire logic overflow_event_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    // reset is checked while it is asserted, so it must not disable itself
    reset_quiet_a: assert property (disable iff (1'h0) rst_i |=> !ack_o && !irq_o
        && periodic_event_o == 8'h00 && match_event_o == 2'h0 && !overflow_event_o)
        else $error("outputs active after reset");
    ack_pulse_a: assert property (ack_o |=> !ack_o)
        else $error("ack held over one cycle");
    ack_cause_a: assert property (ack_o |-> $past(cyc_i) && $past(stb_i))
        else $error("ack without request");
    read_fast_a: assert property (cyc_i && stb_i && !we_i && !ack_o |=> ack_o)
        else $error("read stalled");
    stall_bound_a: assert property (cyc_i && stb_i && !ack_o |-> ##[1:8] ack_o)
        else $error("stall too long");
    read_idle_a: assert property (!ack_o |-> dat_o == 32'h0)
        else $error("read data outside ack");
    periodic_single_a: assert property ($onehot0(periodic_event_o))
        else $error("two periodic events at once");
    periodic_space_a: assert property (periodic_event_o[0] |=> !periodic_event_o[0] [*8])
        else $error("periodic events too close");
    overflow_pulse_a: assert property (overflow_event_o |=> !overflow_event_o)
        else $error("overflow event too long");
    match_pulse_a: assert property (match_event_o[0] |=> !match_event_o[0])
        else $error("match event too long");
endmodule
`default_nettype wire

// ==== verif/rtc_counter_calendar_core_tb_top.sv ====
// self-checking testbench for the rtc counter calendar core
`timescale 1ns/1ns
`default_nettype none
module rtc_counter_calendar_core_tb_top;
    logic clk_i = 1'h0;
    logic rst_i = 1'h1;
    logic src = 1'h0;
    logic halt = 1'h0;
    logic guard = 1'h0;
    logic dbg = 1'h0;
    logic cyc = 1'h0;
    logic stb = 1'h0;
    logic we = 1'h0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wd = 32'h0;
    logic [31:0] rdat;
    logic [31:0] q;
    logic ack;
    logic irq;
    logic oe;
    logic [7:0] pe;
    logic [1:0] me;
    logic [2:0] sdiv = 3'h0;
    int error_cnt = 0;
    int num_checks = 0;
    int ovf_ev = 0;
    always #2 clk_i = ~clk_i;
    // overflow event pulses counted for the first wrap check
    always @(posedge clk_i) ovf_ev += (oe === 1'h1);
    // slow source: eight clocks a period, well above the two-flop minimum
    always @(posedge clk_i)
    begin
        sdiv <= sdiv + 3'h1;
        if (sdiv == 3'h3 || sdiv == 3'h7)
            src <= ~src;
    end
    rtc_counter_calendar_core i_rtc_counter_calendar_core (
        .clk_i(clk_i), .rst_i(rst_i), .timer_source_clock_i(src), .debug_halt_i(halt),
        .write_guard_i(guard), .debugger_access_i(dbg), .cyc_i(cyc), .stb_i(stb),
        .we_i(we), .adr_i(adr), .sel_i(4'hF), .dat_i(wd), .dat_o(rdat), .ack_o(ack),
        .irq_o(irq), .periodic_event_o(pe), .match_event_o(me), .overflow_event_o(oe)
    );
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // single classic cycle; ack and data are taken at the edge that sees ack
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'h1;
        stb <= 1'h1;
        we <= w;
        adr <= a;
        wd <= d;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (ack !== 1'h1 && n < 40);
        q = rdat;
        cyc <= 1'h0;
        stb <= 1'h0;
        we <= 1'h0;
        @(posedge clk_i);
        if (n >= 40)
        begin
            chk("bus ack", 32'h1, 32'h0);
            print_verdict;
        end
    endtask
    task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
        bus(1'h0, a, 32'h0);
        chk(nm, e, q);
    endtask
    task automatic wflag(input int b);
        int n;
        n = 0;
        q = 32'h0;
        while (q[b] !== 1'h1 && n < 200)
        begin
            bus(1'h0, 8'h14, 32'h0);
            n++;
        end
        if (n >= 200)
        begin
            chk("flag wait", 32'h1, 32'h0);
            print_verdict;
        end
    endtask
    function automatic logic [31:0] cal(input int y, mo, d, h, mi, s);
        return {y[5:0], mo[3:0], d[4:0], h[4:0], mi[5:0], s[5:0]};
    endfunction
    // seconds are masked: a second tick may land before the read
    task automatic cal_run(input logic [31:0] c, input logic [31:0] s, input logic [31:0] e);
        int n;
        n = 0;
        bus(1'h1, 8'h14, 32'hFF);
        bus(1'h1, 8'h20, s);
        bus(1'h1, 8'h00, c); // divider shortened, not one hertz
        q = s;
        while (q === s && n < 100)
        begin
            bus(1'h0, 8'h20, 32'h0);
            n++;
        end
        chk("clock", e, q & 32'hFFFFFFC0);
        if (n >= 100)
            print_verdict;
        bus(1'h1, 8'h00, c & 32'hFFFFFFFD);
        idle(5);
    endtask
    task automatic pcount(input int e0, input int e1);
        int n0;
        int n1;
        n0 = 0;
        n1 = 0;
        repeat (256)
        begin
            @(posedge clk_i);
            n0 += (pe[0] === 1'h1);
            n1 += (pe[1] === 1'h1);
        end
        chk("event0 count", e0, n0);
        chk("event1 count", e1, n1);
    endtask
    task automatic t_reset;
        rc("ctrl", 8'h00, 32'h0);
        rc("period", 8'h24, 32'hFFFF);
        bus(1'h1, 8'h40, 32'hFFFFFFFF);
        rc("unmapped", 8'h40, 32'h0);
        $display("reset test done");
    endtask
    task automatic t_cnt;
        bus(1'h1, 8'h14, 32'hFF);
        bus(1'h1, 8'h10, 32'h80);
        bus(1'h1, 8'h08, 32'h8300);
        bus(1'h1, 8'h20, 32'hFFFFFFFE);
        bus(1'h1, 8'h00, 32'h0102);
        bus(1'h1, 8'h00, 32'h0106);
        rc("protected ctrl", 8'h00, 32'h0102);
        wflag(7);
        idle(2);
        chk("irq set", 32'h1, {31'h0, irq});
        chk("overflow event", 32'h1, ovf_ev);
        bus(1'h0, 8'h20, 32'h0);
        chk("wrapped count", 32'h0, q >> 3);
        bus(1'h1, 8'h14, 32'hFF);
        idle(3);
        chk("irq clear", 32'h0, {31'h0, irq});
        bus(1'h1, 8'h00, 32'h0100);
        idle(5);
        bus(1'h1, 8'h14, 32'hFF);
        bus(1'h1, 8'h20, 32'h0);
        bus(1'h1, 8'h28, 32'h3);
        bus(1'h1, 8'h00, 32'h0182);
        wflag(0);
        chk("clear on match", 32'h81, q & 32'h81);
        bus(1'h1, 8'h00, 32'h0180);
        idle(5);
        bus(1'h1, 8'h14, 32'hFF);
        bus(1'h1, 8'h24, 32'h5);
        bus(1'h1, 8'h2C, 32'h4);
        bus(1'h1, 8'h20, 32'h0);
        bus(1'h1, 8'h00, 32'h0106);
        wflag(1);
        chk("no early wrap", 32'h0, {31'h0, q[7]});
        wflag(7);
        bus(1'h0, 8'h20, 32'h0);
        chk("period wrap", 32'h0, q >> 1);
        bus(1'h1, 8'h00, 32'h0104);
        idle(5);
        $display("counter test done");
    endtask
    task automatic t_cal;
        cal_run(32'h010A, cal(63, 12, 31, 23, 59, 59), cal(0, 1, 1, 0, 0, 0));
        bus(1'h0, 8'h14, 32'h0);
        chk("year wrap flag", 32'h1, {31'h0, q[7]});
        cal_run(32'h010A, cal(4, 2, 28, 23, 59, 59), cal(4, 2, 29, 0, 0, 0));
        cal_run(32'h010A, cal(1, 2, 28, 23, 59, 59), cal(1, 3, 1, 0, 0, 0));
        cal_run(32'h014A, cal(2, 5, 9, 11, 59, 59), cal(2, 5, 9, 28, 0, 0));
        bus(1'h1, 8'h28, 32'h5A5A5002);
        bus(1'h1, 8'h30, 32'h1);
        bus(1'h1, 8'h14, 32'hFF);
        bus(1'h1, 8'h00, 32'h010A);
        wflag(0);
        bus(1'h1, 8'h00, 32'h0108);
        idle(5);
        $display("calendar test done");
    endtask
    task automatic t_ev;
        bus(1'h1, 8'h08, 32'h3);
        bus(1'h1, 8'h00, 32'h0102);
        idle(6);
        pcount(4, 2);
        bus(1'h1, 8'h08, 32'h0);
        rc("event control locked", 8'h08, 32'h3);
        bus(1'h1, 8'h00, 32'h0100);
        bus(1'h1, 8'h08, 32'h8000);
        idle(5);
        rc("held event control", 8'h08, 32'h8000);
        bus(1'h1, 8'h08, 32'h3);
        bus(1'h1, 8'h00, 32'h0002);
        idle(6);
        pcount(0, 0);
        bus(1'h1, 8'h00, 32'h0);
        idle(5);
        $display("event test done");
    endtask
    task automatic t_guard;
        guard <= 1'h1;
        bus(1'h1, 8'h24, 32'h10);
        rc("guarded period", 8'h24, 32'h5);
        bus(1'h1, 8'h1C, 32'h1);
        rc("debug control", 8'h1C, 32'h1);
        halt <= 1'h1;
        bus(1'h1, 8'h24, 32'h10);
        idle(5);
        rc("halt bypass", 8'h24, 32'h10);
        halt <= 1'h0;
        dbg <= 1'h1;
        bus(1'h1, 8'h24, 32'h20);
        idle(5);
        rc("debugger bypass", 8'h24, 32'h20);
        dbg <= 1'h0;
        guard <= 1'h0;
        bus(1'h1, 8'h00, 32'h1);
        idle(6);
        rc("soft reset period", 8'h24, 32'hFFFF);
        rc("soft reset ctrl", 8'h00, 32'h0);
        rc("debug control kept", 8'h1C, 32'h1);
        $display("guard test done");
    endtask
    initial
    begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'h0;
        @(posedge clk_i);
        t_reset;
        t_cnt;
        t_cal;
        t_ev;
        t_guard;
        print_verdict;
    end
endmodule
bind rtc_counter_calendar_core rtc_core_monitor i_rtc_core_monitor (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .dat_o(dat_o), .ack_o(ack_o), .irq_o(irq_o), .periodic_event_o(periodic_event_o),
    .match_event_o(match_event_o), .overflow_event_o(overflow_event_o)
);
`default_nettype wire
